// ### include/oms_pkg.sv
// Package holding constants and types for the operation mode selector.
package oms_pkg;

	// Operating modes presented to the rest of the drive.
	typedef enum logic [1:0] {
		OMS_MODE_EXT,
		OMS_MODE_PANEL,
		OMS_MODE_NET,
		OMS_MODE_COMBINED
	} oms_mode_t;

	// APB register byte offsets.
	localparam logic [11:0] OMS_ADDR_CONFIG = 12'h000;
	localparam logic [11:0] OMS_ADDR_STATUS = 12'h004;

	// Field positions in the configuration register.
	localparam int OMS_SEL_LSB   = 0;
	localparam int OMS_START_LSB = 8;
	localparam int OMS_SRC_LSB   = 16;
	localparam int OMS_RPEN_LSB  = 17;
	localparam int OMS_REEN_LSB  = 18;
	localparam int OMS_PEEN_LSB  = 19;

	// Values after reset.
	localparam logic [3:0] OMS_SEL_RESET   = 4'h0;
	localparam logic [3:0] OMS_START_RESET = 4'h0;
	localparam logic       OMS_SRC_RESET   = 1'b1;

	// Startup parameter encodings.
	localparam logic [3:0] OMS_START_SEL   = 4'h0;
	localparam logic [3:0] OMS_START_NET   = 4'h1;
	localparam logic [3:0] OMS_START_PANEL = 4'hA;

	// Mode selection encodings.
	localparam logic [3:0] OMS_SEL_0 = 4'h0;
	localparam logic [3:0] OMS_SEL_1 = 4'h1;
	localparam logic [3:0] OMS_SEL_2 = 4'h2;
	localparam logic [3:0] OMS_SEL_3 = 4'h3;
	localparam logic [3:0] OMS_SEL_4 = 4'h4;
	localparam logic [3:0] OMS_SEL_6 = 4'h6;
	localparam logic [3:0] OMS_SEL_7 = 4'h7;

	// Command source parameter value meaning the option card.
	localparam logic OMS_SRC_OPTION = 1'b0;

endpackage : oms_pkg

// ### logic/oms_operation_mode_selector.sv
// Operation mode selector with APB configuration and terminal switching inputs.
module oms_operation_mode_selector (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [11:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic                    pslverr,
	output logic [31:0]             prdata,
	// Terminal and panel inputs, asynchronous
	input  wire logic               remotePanelSwitch,
	input  wire logic               remoteExternalSwitch,
	input  wire logic               panelExternalSwitch,
	input  wire logic               interlockSignal,
	input  wire logic               motorStopped,
	input  wire logic               startCommand,
	input  wire logic               panelKeyToggle,
	input  wire logic               optionFitted,
	// Mode outputs
	output oms_pkg::oms_mode_t      opMode,
	output logic                    outputStop
);
	import oms_pkg::*;

	logic [3:0] modeSelect;
	logic [3:0] startupMode;
	logic       cmdSource;
	logic       rpAssigned;
	logic       reAssigned;
	logic       peAssigned;
	logic [7:0] syncA;
	logic [7:0] syncB;
	logic       keyLast;
	logic       keyNet;
	logic       initDone;
	oms_mode_t  next_mode;

	// Two-stage synchronisers; only the second stage is read by logic.
	always_ff @(posedge clk) begin
		if (rst) begin
			syncA <= 8'h00;
			syncB <= 8'h00;
		end else begin
			syncA <= {optionFitted, panelKeyToggle, startCommand, motorStopped,
				interlockSignal, panelExternalSwitch, remoteExternalSwitch, remotePanelSwitch};
			syncB <= syncA;
		end
	end

	logic sRp, sRe, sPe, sIl, sStop, sStart, sKey, sOpt;
	assign {sOpt, sKey, sStart, sStop, sIl, sPe, sRe, sRp} = syncB;

	// Stopped means the motor is at rest or the start command is off.
	logic idle;
	assign idle = sStop || !sStart;

	function automatic logic legalSel(input logic [3:0] v);
		legalSel = (v <= OMS_SEL_4) || (v == OMS_SEL_6) || (v == OMS_SEL_7);
	endfunction : legalSel

	function automatic logic legalStart(input logic [3:0] v);
		legalStart = (v == OMS_START_SEL) || (v == OMS_START_NET) || (v == OMS_START_PANEL);
	endfunction : legalStart

	// Network requests fall back to panel when the option source is missing.
	function automatic oms_mode_t netOrPanel(input logic src, input logic opt);
		netOrPanel = (src == OMS_SRC_OPTION && !opt) ? OMS_MODE_PANEL : OMS_MODE_NET;
	endfunction : netOrPanel

	// APB access; single-cycle answer, unmapped addresses error.
	logic apbWrite, apbRead, cfgHit, staHit, cfgOk;
	assign apbWrite = psel && penable && pwrite;
	assign apbRead  = psel && penable && !pwrite;
	assign cfgHit   = (paddr == OMS_ADDR_CONFIG);
	assign staHit   = (paddr == OMS_ADDR_STATUS);
	assign cfgOk    = legalSel(pwdata[OMS_SEL_LSB +: 4]) && legalStart(pwdata[OMS_START_LSB +: 4]) && idle;

	always_ff @(posedge clk) begin
		if (rst) begin
			modeSelect  <= OMS_SEL_RESET;
			startupMode <= OMS_START_RESET;
			cmdSource   <= OMS_SRC_RESET;
			rpAssigned  <= 1'b0;
			reAssigned  <= 1'b0;
			peAssigned  <= 1'b0;
		end else if (apbWrite && cfgHit && cfgOk) begin
			modeSelect  <= pwdata[OMS_SEL_LSB +: 4];
			startupMode <= pwdata[OMS_START_LSB +: 4];
			cmdSource   <= pwdata[OMS_SRC_LSB];
			rpAssigned  <= pwdata[OMS_RPEN_LSB];
			reAssigned  <= pwdata[OMS_REEN_LSB];
			peAssigned  <= pwdata[OMS_PEEN_LSB];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !(paddr == OMS_ADDR_CONFIG && (!pwrite || cfgOk)) &&
				!(paddr == OMS_ADDR_STATUS && !pwrite);
			prdata  <= 32'h00000000;
			if (psel && !penable && !pwrite && paddr == OMS_ADDR_CONFIG) begin
				prdata[OMS_SEL_LSB +: 4]   <= modeSelect;
				prdata[OMS_START_LSB +: 4] <= startupMode;
				prdata[OMS_SRC_LSB]        <= cmdSource;
				prdata[OMS_RPEN_LSB]       <= rpAssigned;
				prdata[OMS_REEN_LSB]       <= reAssigned;
				prdata[OMS_PEEN_LSB]       <= peAssigned;
			end else if (psel && !penable && !pwrite && paddr == OMS_ADDR_STATUS) begin
				prdata <= {24'h000000, sRp, sRe, sPe, sIl, outputStop, idle, opMode};
			end
		end
	end

	// The error answer is decided in the setup cycle, so it must agree with the write gate one edge later.
	AST_RUN_REFUSED: assert property (@(posedge clk) disable iff (rst)
		psel && !penable && pwrite && cfgHit && !idle |=> pslverr)
		else $error("Write while running was not refused.");
	AST_SEL_REFUSED: assert property (@(posedge clk) disable iff (rst)
		psel && !penable && pwrite && cfgHit && !legalSel(pwdata[OMS_SEL_LSB +: 4]) |=> pslverr)
		else $error("Illegal selection was not refused.");
	AST_START_REFUSED: assert property (@(posedge clk) disable iff (rst)
		psel && !penable && pwrite && cfgHit && !legalStart(pwdata[OMS_START_LSB +: 4]) |=> pslverr)
		else $error("Illegal startup value was not refused.");
	AST_BAD_KEEPS: assert property (@(posedge clk) disable iff (rst)
		apbWrite && !cfgOk |=> $stable(modeSelect) && $stable(startupMode))
		else $error("Refused write changed a parameter.");
	AST_STOP_WRITE: assert property (@(posedge clk) disable iff (rst)
		psel && !penable && pwrite && cfgHit && idle && legalSel(pwdata[OMS_SEL_LSB +: 4]) &&
		legalStart(pwdata[OMS_START_LSB +: 4]) |=> !pslverr)
		else $error("Legal write while stopped was refused.");

	// Panel key toggle between panel and network under startup 10.
	always_ff @(posedge clk) begin
		if (rst) begin
			keyLast <= 1'b0;
			keyNet  <= 1'b1;
		end else begin
			keyLast <= sKey;
			if (sKey && !keyLast && startupMode == OMS_START_PANEL) begin
				keyNet <= !keyNet;
			end
		end
	end

	// The toggle moves only on a fresh key press under startup 10.
	AST_KEY_FLIP: assert property (@(posedge clk) disable iff (rst)
		startupMode == OMS_START_PANEL && sKey && !keyLast |=> keyNet != $past(keyNet))
		else $error("Panel key did not toggle the mode.");
	AST_KEY_STILL: assert property (@(posedge clk) disable iff (rst)
		!(sKey && !keyLast) |=> $stable(keyNet))
		else $error("Panel toggle moved without a key press.");

	// Target mode; the evaluation order follows the source priority.
	oms_mode_t target;
	logic      interlocked;
	always_comb begin
		target      = OMS_MODE_EXT;
		interlocked = 1'b0;
		case (modeSelect)
			OMS_SEL_1: target = OMS_MODE_PANEL;
			OMS_SEL_3, OMS_SEL_4: target = OMS_MODE_COMBINED;
			OMS_SEL_2: begin
				if (startupMode == OMS_START_PANEL) begin
					target = netOrPanel(cmdSource, sOpt);
				end else if (reAssigned && sRe) begin
					target = netOrPanel(cmdSource, sOpt);
				end else begin
					target = OMS_MODE_EXT;
				end
			end
			OMS_SEL_7: begin
				if (!sIl) begin
					target = OMS_MODE_EXT;
				end else if (startupMode == OMS_START_PANEL) begin
					target = (peAssigned && sPe) ? OMS_MODE_EXT : OMS_MODE_PANEL;
					interlocked = 1'b1;
				end else if (reAssigned && sRe) begin
					target = netOrPanel(cmdSource, sOpt);
				end else begin
					target = (peAssigned && !sPe) ? OMS_MODE_PANEL : OMS_MODE_EXT;
					interlocked = 1'b1;
				end
			end
			OMS_SEL_0, OMS_SEL_6: begin
				if (startupMode == OMS_START_PANEL) begin
					if (reAssigned && sRe) begin
						target = netOrPanel(cmdSource, sOpt);
					end else if (rpAssigned) begin
						target = sRp ? OMS_MODE_PANEL : netOrPanel(cmdSource, sOpt);
					end else begin
						target = keyNet ? netOrPanel(cmdSource, sOpt) : OMS_MODE_PANEL;
					end
					if (target == OMS_MODE_NET && peAssigned && !sPe) begin
						target = OMS_MODE_PANEL;
					end
				end else if (reAssigned && sRe) begin
					target = netOrPanel(cmdSource, sOpt);
				end else if (rpAssigned) begin
					target = sRp ? OMS_MODE_PANEL : netOrPanel(cmdSource, sOpt);
				end else if (peAssigned) begin
					target = sPe ? OMS_MODE_EXT : OMS_MODE_PANEL;
				end else begin
					// An assigned remote/external terminal that reads low asks for external, even under startup 1.
					target = (startupMode == OMS_START_NET && !reAssigned) ? netOrPanel(cmdSource, sOpt) :
						OMS_MODE_EXT;
				end
			end
			default: target = OMS_MODE_EXT;
		endcase
	end

	// Links of the priority chain, except the panel key and fallback picks, are checked on the combinational target, because a
	// wrong pick would otherwise hide behind the hold that applies while running.
	logic noOption;
	logic start10;
	logic sel06;
	logic reHigh;
	assign noOption = (cmdSource == OMS_SRC_OPTION) && !sOpt;
	assign start10  = (startupMode == OMS_START_PANEL);
	assign sel06    = (modeSelect == OMS_SEL_0) || (modeSelect == OMS_SEL_6);
	assign reHigh   = reAssigned && sRe;

	AST_T_SEL1: assert property (@(posedge clk) disable iff (rst)
		modeSelect == OMS_SEL_1 |-> target == OMS_MODE_PANEL)
		else $error("Selection 1 target is not panel.");
	AST_T_COMB: assert property (@(posedge clk) disable iff (rst)
		modeSelect == OMS_SEL_3 || modeSelect == OMS_SEL_4 |-> target == OMS_MODE_COMBINED)
		else $error("Selection 3 or 4 target is not combined.");
	AST_T_NET10: assert property (@(posedge clk) disable iff (rst)
		start10 && modeSelect == OMS_SEL_2 && !noOption |-> target == OMS_MODE_NET)
		else $error("Startup 10 selection 2 target is not network.");
	AST_T_IL_LOW: assert property (@(posedge clk) disable iff (rst)
		modeSelect == OMS_SEL_7 && !sIl |-> target == OMS_MODE_EXT)
		else $error("Interlock low target is not external.");
	AST_T_NO_NET7: assert property (@(posedge clk) disable iff (rst)
		start10 && modeSelect == OMS_SEL_7 |-> target != OMS_MODE_NET)
		else $error("Startup 10 selection 7 target is network.");
	AST_T_PE7: assert property (@(posedge clk) disable iff (rst)
		start10 && modeSelect == OMS_SEL_7 && sIl && peAssigned && sPe |-> target == OMS_MODE_EXT)
		else $error("Panel/external high target is not external.");
	AST_T_NOOPT: assert property (@(posedge clk) disable iff (rst)
		noOption |-> target != OMS_MODE_NET)
		else $error("Network chosen without a command source.");
	AST_T_PE_LOW10: assert property (@(posedge clk) disable iff (rst)
		start10 && sel06 && peAssigned && !sPe |-> target != OMS_MODE_NET)
		else $error("Startup 10 network chosen with panel/external low.");
	AST_T_RP10: assert property (@(posedge clk) disable iff (rst)
		start10 && sel06 && rpAssigned && sRp && !reHigh |-> target == OMS_MODE_PANEL)
		else $error("Remote/panel high target is not panel.");
	AST_T_RE10: assert property (@(posedge clk) disable iff (rst)
		start10 && sel06 && reHigh && !noOption && !(peAssigned && !sPe) |-> target == OMS_MODE_NET)
		else $error("Remote/external high did not override under startup 10.");
	AST_T_RE01: assert property (@(posedge clk) disable iff (rst)
		!start10 && (sel06 || modeSelect == OMS_SEL_2) && reHigh && !noOption |-> target == OMS_MODE_NET)
		else $error("Remote/external high target is not network.");
	AST_T_RE_LOW: assert property (@(posedge clk) disable iff (rst)
		!start10 && sel06 && reAssigned && !sRe && !rpAssigned && !peAssigned |-> target == OMS_MODE_EXT)
		else $error("Remote/external low target is not external.");
	AST_T_RE7: assert property (@(posedge clk) disable iff (rst)
		!start10 && modeSelect == OMS_SEL_7 && sIl && reHigh && !noOption |-> target == OMS_MODE_NET)
		else $error("Interlocked remote/external high target is not network.");
	AST_T_RP01: assert property (@(posedge clk) disable iff (rst)
		!start10 && sel06 && !reHigh && rpAssigned && sRp |-> target == OMS_MODE_PANEL)
		else $error("Remote/panel did not decide with remote/external low.");
	AST_T_PE01: assert property (@(posedge clk) disable iff (rst)
		!start10 && sel06 && !reHigh && !rpAssigned && peAssigned && !sPe |-> target == OMS_MODE_PANEL)
		else $error("Panel/external low target is not panel.");

	// Fixed and forced modes take effect at once; switched modes wait for idle
	// unless selection 6 is active.
	logic forced;
	assign forced = (modeSelect == OMS_SEL_1) || (modeSelect == OMS_SEL_3) ||
		(modeSelect == OMS_SEL_4) || (modeSelect == OMS_SEL_7 && !sIl);

	always_comb begin
		next_mode = opMode;
		if (forced || modeSelect == OMS_SEL_6 || idle) begin
			next_mode = target;
		end
	end

	// Startup mode is applied once, on the first edge after reset, while the synchronisers still read all zeros.
	always_ff @(posedge clk) begin
		if (rst) begin
			opMode     <= OMS_MODE_EXT;
			outputStop <= 1'b0;
			initDone   <= 1'b0;
		end else if (!initDone) begin
			initDone <= 1'b1;
			if (startupMode != OMS_START_SEL && modeSelect != OMS_SEL_1 &&
				modeSelect != OMS_SEL_3 && modeSelect != OMS_SEL_4 && modeSelect != OMS_SEL_7) begin
				opMode <= OMS_MODE_NET;
			end else begin
				opMode <= target;
			end
		end else begin
			opMode     <= next_mode;
			outputStop <= interlocked && next_mode == OMS_MODE_EXT && modeSelect == OMS_SEL_7;
		end
	end

	AST_HOLD_RUN: assert property (@(posedge clk) disable iff (rst)
		initDone && !idle && !forced && modeSelect != OMS_SEL_6 |=> $stable(opMode))
		else $error("Mode changed while running.");
	AST_SEL1: assert property (@(posedge clk) disable iff (rst)
		initDone && modeSelect == OMS_SEL_1 |=> opMode == OMS_MODE_PANEL)
		else $error("Selection 1 not panel.");
	AST_COMB: assert property (@(posedge clk) disable iff (rst)
		initDone && (modeSelect == OMS_SEL_3 || modeSelect == OMS_SEL_4) |=> opMode == OMS_MODE_COMBINED)
		else $error("Combined mode not held.");
	AST_FORCE_EXT: assert property (@(posedge clk) disable iff (rst)
		initDone && modeSelect == OMS_SEL_7 && !sIl |=> opMode == OMS_MODE_EXT)
		else $error("Interlock low did not force external.");
	AST_NO_EXT10: assert property (@(posedge clk) disable iff (rst)
		startupMode == OMS_START_PANEL && (modeSelect == OMS_SEL_0 || modeSelect == OMS_SEL_6) |-> target != OMS_MODE_EXT)
		else $error("Startup 10 chose external.");
	AST_NO_PANEL2: assert property (@(posedge clk) disable iff (rst)
		startupMode != OMS_START_PANEL && modeSelect == OMS_SEL_2 && !(cmdSource == OMS_SRC_OPTION && !sOpt) |->
		target != OMS_MODE_PANEL)
		else $error("Selection 2 chose panel.");
	AST_LEGAL: assert property (@(posedge clk) disable iff (rst)
		legalSel(modeSelect) && legalStart(startupMode))
		else $error("Illegal parameter stored.");
	AST_RUN_WRITE: assert property (@(posedge clk) disable iff (rst)
		apbWrite && !idle |=> $stable(modeSelect) && $stable(startupMode))
		else $error("Parameter written while running.");

	// The mode register follows the target whenever a change is allowed.
	AST_APPLY_IDLE: assert property (@(posedge clk) disable iff (rst)
		initDone && idle |=> opMode == $past(target))
		else $error("Stopped drive did not take the target mode.");
	AST_APPLY_RUN6: assert property (@(posedge clk) disable iff (rst)
		initDone && modeSelect == OMS_SEL_6 |=> opMode == $past(target))
		else $error("Selection 6 did not switch while running.");
	AST_INIT_SEL: assert property (@(posedge clk) disable iff (rst)
		!initDone && startupMode == OMS_START_SEL |=> opMode == $past(target))
		else $error("Startup mode did not follow the selection.");
	AST_INIT_ONCE: assert property (@(posedge clk) disable iff (rst)
		initDone |=> initDone)
		else $error("Startup mode applied twice.");
	AST_STOP_EXT: assert property (@(posedge clk) disable iff (rst)
		outputStop |-> opMode == OMS_MODE_EXT)
		else $error("Output stop outside external mode.");
	AST_STOP_IL: assert property (@(posedge clk) disable iff (rst)
		initDone && !sIl |=> !outputStop)
		else $error("Output stop with interlock low.");

endmodule : oms_operation_mode_selector

// ### test/oms_terminal_model.sv
// Terminal, panel key and option card side of the operation mode selector.
module oms_terminal_model (
	// Clock
	input  wire logic       clk,
	// Levels requested by the bench
	input  wire logic [7:0] pinReq,
	// Levels seen at the selector's terminals
	output logic      [7:0] pins
);
	timeunit 1ns;
	timeprecision 100ps;
	import oms_pkg::*;

	// Terminal levels move only just after an edge, as a real input card would.
	always @(posedge clk) begin
		pins <= pinReq;
	end

	// A terminal function code is what gives a switching signal a terminal at all.
	function automatic logic [31:0] assignWord(input logic [7:0] code);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (code)
			8'h41: w[OMS_RPEN_LSB] = 1'b1;
			8'h42: w[OMS_REEN_LSB] = 1'b1;
			8'h10: w[OMS_PEEN_LSB] = 1'b1;
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction : assignWord
endmodule : oms_terminal_model

// ### test/testbench.sv
// Self-checking bench for the operation mode selector.
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import oms_pkg::*;
	localparam logic [7:0] RP = 8'h01, RX = 8'h02, PE = 8'h04, IL = 8'h08;
	localparam logic [7:0] ST = 8'h10, GO = 8'h20, KY = 8'h40, OP = 8'h80;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic [7:0]  pinReq = 8'h90;
	logic [7:0]  pins;
	oms_mode_t   opMode;
	logic        outputStop;
	logic [31:0] rd;
	logic        er;
	logic [31:0] asg;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	always #2.5 clk = ~clk;

	oms_terminal_model oms_terminal_model_inst (.clk(clk), .pinReq(pinReq), .pins(pins));

	oms_operation_mode_selector oms_operation_mode_selector_inst (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.remotePanelSwitch(pins[0]), .remoteExternalSwitch(pins[1]), .panelExternalSwitch(pins[2]),
		.interlockSignal(pins[3]), .motorStopped(pins[4]), .startCommand(pins[5]),
		.panelKeyToggle(pins[6]), .optionFitted(pins[7]), .opMode(opMode), .outputStop(outputStop)
	);

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	// A hung handshake would otherwise stall the run forever.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wcfg(input logic [3:0] sel, input logic [3:0] st, input logic src);
		apb(1'b1, OMS_ADDR_CONFIG, asg | {15'h0, src, 4'h0, st, 4'h0, sel});
		chk({31'h0, er}, 32'h0);
	endtask : wcfg

	// Six edges cover the model register, the two-stage sync and the mode register.
	task automatic pm(input logic [7:0] p, input oms_mode_t m);
		@(posedge clk);
		pinReq <= p;
		repeat (6) @(posedge clk);
		chk({30'h0, opMode}, {30'h0, m});
	endtask : pm

	task automatic t_regs;
		apb(1'b0, OMS_ADDR_CONFIG, 32'h0);
		chk(rd, {15'h0, OMS_SRC_RESET, 4'h0, OMS_START_RESET, 4'h0, OMS_SEL_RESET});
		apb(1'b0, OMS_ADDR_STATUS, 32'h0);
		chk(rd, 32'h0000_0004);
		apb(1'b1, OMS_ADDR_STATUS, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, OMS_ADDR_CONFIG, 32'h0001_0005);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, OMS_ADDR_CONFIG, 32'h0001_0204);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, OMS_ADDR_CONFIG, 32'h0);
		chk(rd, 32'h0001_0000);
	endtask : t_regs

	task automatic t_ext;
		asg = oms_terminal_model_inst.assignWord(8'h42);
		wcfg(OMS_SEL_0, OMS_START_NET, 1'b1);
		pm(ST | OP, OMS_MODE_EXT);
		pm(ST | OP | RX, OMS_MODE_NET);
		asg = oms_terminal_model_inst.assignWord(8'h42) | oms_terminal_model_inst.assignWord(8'h10);
		wcfg(OMS_SEL_0, OMS_START_SEL, 1'b1);
		pm(ST | OP | RX, OMS_MODE_NET);
		pm(ST | OP | PE, OMS_MODE_EXT);
		pm(ST | OP, OMS_MODE_PANEL);
		wcfg(OMS_SEL_2, OMS_START_SEL, 1'b1);
		pm(ST | OP, OMS_MODE_EXT);
		pm(ST | OP | RX, OMS_MODE_NET);
		wcfg(OMS_SEL_7, OMS_START_NET, 1'b1);
		pm(ST | OP | RX, OMS_MODE_EXT);
		chk({31'h0, outputStop}, 32'h0);
		pm(ST | OP | RX | IL, OMS_MODE_NET);
		pm(ST | OP | PE | IL, OMS_MODE_EXT);
		chk({31'h0, outputStop}, 32'h1);
		wcfg(OMS_SEL_3, OMS_START_SEL, 1'b1);
		pm(ST | OP | RX, OMS_MODE_COMBINED);
	endtask : t_ext

	task automatic t_run;
		wcfg(OMS_SEL_0, OMS_START_SEL, 1'b1);
		pm(ST | OP | PE, OMS_MODE_EXT);
		pm(GO | OP | PE, OMS_MODE_EXT);
		apb(1'b1, OMS_ADDR_CONFIG, 32'h0001_0006);
		chk({31'h0, er}, 32'h1);
		pm(GO | OP | PE | RX, OMS_MODE_EXT);
		pm(ST | GO | OP | PE | RX, OMS_MODE_NET);
		wcfg(OMS_SEL_6, OMS_START_SEL, 1'b1);
		pm(GO | OP | PE, OMS_MODE_EXT);
		pm(GO | OP | PE | RX, OMS_MODE_NET);
		pm(ST | OP | PE, OMS_MODE_EXT);
	endtask : t_run

	task automatic t_net10;
		wcfg(OMS_SEL_0, OMS_START_PANEL, 1'b1);
		pm(ST | OP | PE, OMS_MODE_NET);
		pm(ST | OP | PE | KY, OMS_MODE_PANEL);
		pm(ST | OP | PE | KY | RX, OMS_MODE_NET);
		asg = asg | oms_terminal_model_inst.assignWord(8'h41);
		wcfg(OMS_SEL_0, OMS_START_PANEL, 1'b1);
		pm(ST | OP | PE | RP, OMS_MODE_PANEL);
		pm(ST | OP | PE, OMS_MODE_NET);
		pm(ST | OP | PE | RP | RX, OMS_MODE_NET);
		wcfg(OMS_SEL_6, OMS_START_PANEL, 1'b0);
		pm(ST | PE, OMS_MODE_PANEL);
		wcfg(OMS_SEL_1, OMS_START_PANEL, 1'b1);
		pm(ST | OP | PE, OMS_MODE_PANEL);
		wcfg(OMS_SEL_2, OMS_START_PANEL, 1'b1);
		pm(ST | OP | PE | RP, OMS_MODE_NET);
		wcfg(OMS_SEL_4, OMS_START_PANEL, 1'b1);
		pm(ST | OP | PE, OMS_MODE_COMBINED);
		wcfg(OMS_SEL_7, OMS_START_PANEL, 1'b1);
		pm(ST | OP | IL, OMS_MODE_PANEL);
		pm(ST | OP | IL | PE, OMS_MODE_EXT);
		chk({31'h0, outputStop}, 32'h1);
		pm(ST | OP | PE, OMS_MODE_EXT);
		chk({31'h0, outputStop}, 32'h0);
	endtask : t_net10

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_regs();
		t_ext();
		t_run();
		t_net10();
		conclude();
	end
endmodule : testbench
